//--- common/dsl_flags_if.sv
`default_nettype none

// Conditioned comparator flags passed to the sequencer
interface dsl_flags_if #(
  parameter int N = 5
);
  // One synchronised flag per monitored level, hysteretic except headroom ok
  logic [N-1:0] flags;

  // Producer side
  modport src (output flags);
  // Consumer side
  modport dst (input flags);
endinterface

`default_nettype wire

//--- common/dsl_pkg.sv
`default_nettype none

package dsl_pkg;

  // Comparator thresholds in millivolts and degrees Celsius
  localparam int SUPPLY_DIS_MV = 6750;
  localparam int SUPPLY_ENA_MV = 7500;
  localparam int BUS_UVL_MV = 400;
  localparam int BUS_UVU_MV = 500;
  localparam int BUS_OVU_MV = 1250;
  localparam int BUS_OVL_MV = 1150;
  localparam int HEAD_RUN_MV = 1250;
  localparam int TEMP_DIS_C = 145;
  localparam int TEMP_ENA_C = 130;
  // Level the start-state charge source ramps the gain network to
  localparam int CHARGE_TARGET_MV = 1000;
  // Enabled edges after reset before the conditioned flags are valid
  localparam int SETTLE_EDGES = 3;

  // Flag positions inside the conditioned flag vector
  localparam int NUM_FLAGS = 5;
  localparam int FLG_SUPPLY_UV = 0;
  localparam int FLG_BUS_UV = 1;
  localparam int FLG_BUS_OV = 2;
  localparam int FLG_HEAD_OK = 3;
  localparam int FLG_OVERTEMP = 4;

  // Sequencer states, Gray coded along idle, start, run
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_RUN = 2'h3
  } dsl_state_t;

  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_EVCLR = 8'h08;
  localparam logic [7:0] REG_EVEN = 8'h0C;

  // Status field positions
  localparam int ST_INHIBIT_BIT = 5;
  localparam int ST_STATE_LSB = 6;

  // Event bit positions
  localparam int NUM_EVENTS = 5;
  localparam int EV_INHIBIT = 0;
  localparam int EV_START = 1;
  localparam int EV_RUN = 2;
  localparam int EV_OVERTEMP = 3;
  localparam int EV_RUN_LOST = 4;

  // Reset values
  localparam logic [NUM_EVENTS-1:0] EVENT_RST = 5'h00;
  localparam logic [NUM_EVENTS-1:0] EVEN_RST = 5'h00;

endpackage

`default_nettype wire

//--- design/dsl_flag_conditioner.sv
`default_nettype none

// Synchronises comparator pins and holds each flag between thresholds
module dsl_flag_conditioner #(
  parameter int N = 5
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Raw comparator pins: set and clear conditions per flag
  input wire logic [N-1:0] set_raw_i,
  input wire logic [N-1:0] clr_raw_i,
  // Conditioned flags
  dsl_flags_if.src flags_if
);

  genvar g;

  generate
    for (g = 0; g < N; g++)
    begin : gen_flag
      // Two stage synchronisers, first stage read only by second
      logic set_m, set_s, clr_m, clr_s;
      // Held flag
      logic flag;

      // Two flip-flops before any logic sees a pin
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          set_m <= 1'b0;
          set_s <= 1'b0;
          clr_m <= 1'b0;
          clr_s <= 1'b0;
        end
        else if (ce_i)
        begin
          set_m <= set_raw_i[g];
          set_s <= set_m;
          clr_m <= clr_raw_i[g];
          clr_s <= clr_m;
        end
      end

      // Set on one threshold, clear only past the other
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          flag <= 1'b0;
        else if (ce_i)
        begin
          if (set_s)
            flag <= 1'b1;
          else if (clr_s)
            flag <= 1'b0;
        end
      end

      assign flags_if.flags[g] = flag;
    end
  endgenerate

endmodule

`default_nettype wire

//--- design/dsl_top.sv
// The address map and register access over Wishbone were decided locally.
`default_nettype none

// Supervisory sequencer of the LED driver with a Wishbone status port
module dsl_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,

  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,

  // Supply comparator pins
  input wire logic supply_below_dis_i,
  input wire logic supply_above_ena_i,

  // Bus sense comparator pins
  input wire logic bus_below_uvl_i,
  input wire logic bus_above_uvu_i,
  input wire logic bus_above_ovu_i,
  input wire logic bus_below_ovl_i,

  // Headroom sense comparator pin
  input wire logic headroom_above_run_i,

  // Die temperature comparator pins
  input wire logic temp_above_dis_i,
  input wire logic temp_below_ena_i,

  // Headroom amplifier output mode
  output logic amp_ground_o,
  output logic amp_charge_en_o,
  output logic amp_loop_en_o,

  // Converter and reference control
  output logic switching_en_o,
  output logic full_ref_o,
  output logic inhibit_o,

  // Interrupt
  output logic irq_o
);

  // Pin conditions that set each flag
  logic [dsl_pkg::NUM_FLAGS-1:0] set_raw;
  // Pin conditions that clear each flag
  logic [dsl_pkg::NUM_FLAGS-1:0] clr_raw;

  // Conditioned flags from the conditioner
  dsl_flags_if #(.N(dsl_pkg::NUM_FLAGS)) flags_if ();

  // Named views of the conditioned flags
  logic supply_undervoltage_flag;
  logic bus_undervoltage_flag;
  logic bus_overvoltage_flag;
  logic headroom_ok_flag;
  logic overtemperature_flag;

  // Fault combination
  logic inhibit_req;

  // Sequencer state
  dsl_pkg::dsl_state_t state;
  dsl_pkg::dsl_state_t next_state;

  // Ones shift in after reset; the top bit marks the flags valid
  logic [dsl_pkg::SETTLE_EDGES-1:0] settle_sr;

  // Previous values for event edges
  logic inhibit_prev;
  logic overtemp_prev;

  // Events raised this cycle
  logic [dsl_pkg::NUM_EVENTS-1:0] ev_set;
  // Sticky events, enables and clear strobe
  logic [dsl_pkg::NUM_EVENTS-1:0] ev_status;
  logic [dsl_pkg::NUM_EVENTS-1:0] ev_enable;
  logic [dsl_pkg::NUM_EVENTS-1:0] ev_clear;

  // Bus request qualifiers
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_data;

  // Amplifier mode per state: ground, charge, loop
  function automatic logic [2:0] amp_mode(dsl_pkg::dsl_state_t s);
    logic [2:0] m;
    m = 3'h4;
    case (s)
      dsl_pkg::ST_IDLE:
        m = 3'h4;
      dsl_pkg::ST_START:
        m = 3'h2;
      dsl_pkg::ST_RUN:
        m = 3'h1;
      default:
        m = 3'h4;
    endcase
    return m;
  endfunction

  // Map pins onto the flag set and clear conditions
  always_comb
  begin
    set_raw = '0;
    clr_raw = '0;
    // Supply below 6.75V sets, above 7.5V clears
    set_raw[dsl_pkg::FLG_SUPPLY_UV] = supply_below_dis_i;
    clr_raw[dsl_pkg::FLG_SUPPLY_UV] = supply_above_ena_i;
    // Bus sense below 0.4V sets, above 0.5V clears
    set_raw[dsl_pkg::FLG_BUS_UV] = bus_below_uvl_i;
    clr_raw[dsl_pkg::FLG_BUS_UV] = bus_above_uvu_i;
    // Bus sense above 1.25V sets, below 1.15V clears
    set_raw[dsl_pkg::FLG_BUS_OV] = bus_above_ovu_i;
    clr_raw[dsl_pkg::FLG_BUS_OV] = bus_below_ovl_i;
    // One threshold both ways, so no hysteresis band
    set_raw[dsl_pkg::FLG_HEAD_OK] = headroom_above_run_i;
    clr_raw[dsl_pkg::FLG_HEAD_OK] = ~headroom_above_run_i;
    // Above 145C sets, below 130C clears
    set_raw[dsl_pkg::FLG_OVERTEMP] = temp_above_dis_i;
    clr_raw[dsl_pkg::FLG_OVERTEMP] = temp_below_ena_i;
  end

  // Synchronise and hold the comparator flags
  dsl_flag_conditioner #(
    .N(dsl_pkg::NUM_FLAGS)
  ) u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_raw_i(set_raw),
    .clr_raw_i(clr_raw),
    .flags_if(flags_if.src)
  );

  // Name the conditioned flags
  assign supply_undervoltage_flag = flags_if.flags[dsl_pkg::FLG_SUPPLY_UV];
  assign bus_undervoltage_flag = flags_if.flags[dsl_pkg::FLG_BUS_UV];
  assign bus_overvoltage_flag = flags_if.flags[dsl_pkg::FLG_BUS_OV];
  assign headroom_ok_flag = flags_if.flags[dsl_pkg::FLG_HEAD_OK];
  assign overtemperature_flag = flags_if.flags[dsl_pkg::FLG_OVERTEMP];

  // Any fault inhibits; only all clear releases
  assign inhibit_req = supply_undervoltage_flag
    | bus_undervoltage_flag
    | bus_overvoltage_flag
    | overtemperature_flag;

  // Next state of the sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      dsl_pkg::ST_IDLE:
      begin
        // Leave idle only once inhibit is gone
        if (!inhibit_req)
          next_state = dsl_pkg::ST_START;
        else
          next_state = dsl_pkg::ST_IDLE;
      end
      dsl_pkg::ST_START:
      begin
        // Inhibit beats headroom ok
        if (inhibit_req)
          next_state = dsl_pkg::ST_IDLE;
        else if (headroom_ok_flag)
          next_state = dsl_pkg::ST_RUN;
      end
      dsl_pkg::ST_RUN:
      begin
        // Headroom ok is not looked at here
        if (inhibit_req)
          next_state = dsl_pkg::ST_IDLE;
      end
      default:
        next_state = dsl_pkg::ST_IDLE;
    endcase
    // Overtemperature always lands in idle
    if (overtemperature_flag)
      next_state = dsl_pkg::ST_IDLE;
    // Flags still filling after reset would hide a power-up fault
    if (!settle_sr[dsl_pkg::SETTLE_EDGES-1])
      next_state = dsl_pkg::ST_IDLE;
  end

  // Counts the synchroniser fill time after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      settle_sr <= '0;
    else if (ce_i)
      settle_sr <= {settle_sr[dsl_pkg::SETTLE_EDGES-2:0], 1'b1};
  end

  // State register, idle from reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= dsl_pkg::ST_IDLE;
    else if (ce_i)
      state <= next_state;
  end

  // Output register, follows the state in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      amp_ground_o <= 1'b1;
      amp_charge_en_o <= 1'b0;
      amp_loop_en_o <= 1'b0;
      switching_en_o <= 1'b0;
      full_ref_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // Amplifier mode decoded from the coming state
      {amp_ground_o, amp_charge_en_o, amp_loop_en_o}
        <= amp_mode(next_state);
      // Converter switches outside idle
      switching_en_o <= (next_state != dsl_pkg::ST_IDLE);
      // Full current reference only while running
      full_ref_o <= (next_state == dsl_pkg::ST_RUN);
    end
  end

  // Registered inhibit and edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inhibit_o <= 1'b0;
      inhibit_prev <= 1'b0;
      overtemp_prev <= 1'b0;
    end
    else if (ce_i)
    begin
      inhibit_o <= inhibit_req;
      inhibit_prev <= inhibit_req;
      overtemp_prev <= overtemperature_flag;
    end
  end

  // Events raised this cycle
  always_comb
  begin
    ev_set = '0;
    // Inhibit rising
    ev_set[dsl_pkg::EV_INHIBIT] = inhibit_req & ~inhibit_prev;
    // Start entered
    ev_set[dsl_pkg::EV_START] = (state != dsl_pkg::ST_START)
      && (next_state == dsl_pkg::ST_START);
    // Run entered
    ev_set[dsl_pkg::EV_RUN] = (state != dsl_pkg::ST_RUN)
      && (next_state == dsl_pkg::ST_RUN);
    // Overtemperature rising
    ev_set[dsl_pkg::EV_OVERTEMP] = overtemperature_flag & ~overtemp_prev;
    // Fall from run back to idle
    ev_set[dsl_pkg::EV_RUN_LOST] = (state == dsl_pkg::ST_RUN)
      && (next_state == dsl_pkg::ST_IDLE);
  end

  // Bus request decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge at which the master sees acknowledge
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Write-one-to-clear strobe for the event register
  always_comb
  begin
    ev_clear = '0;
    if (bus_wr && (wb_adr_i == dsl_pkg::REG_EVCLR))
      ev_clear = wb_dat_i[dsl_pkg::NUM_EVENTS-1:0];
  end

  // Sticky events; a new event wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ev_status <= dsl_pkg::EVENT_RST;
    else if (ce_i)
      ev_status <= (ev_status & ~ev_clear) | ev_set;
  end

  // Event enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ev_enable <= dsl_pkg::EVEN_RST;
    else if (ce_i && bus_wr && (wb_adr_i == dsl_pkg::REG_EVEN))
      ev_enable <= wb_dat_i[dsl_pkg::NUM_EVENTS-1:0];
  end

  // Interrupt level, registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(((ev_status & ~ev_clear) | ev_set) & ev_enable);
  end

  // Read multiplexer; unmapped and write-only read as zero
  always_comb
  begin
    rd_data = '0;
    if (wb_adr_i == dsl_pkg::REG_STATUS)
    begin
      rd_data[dsl_pkg::NUM_FLAGS-1:0] = flags_if.flags;
      rd_data[dsl_pkg::ST_INHIBIT_BIT] = inhibit_req;
      rd_data[dsl_pkg::ST_STATE_LSB +: 2] = state;
    end
    else if (wb_adr_i == dsl_pkg::REG_EVENT)
      rd_data[dsl_pkg::NUM_EVENTS-1:0] = ev_status;
    else if (wb_adr_i == dsl_pkg::REG_EVEN)
      rd_data[dsl_pkg::NUM_EVENTS-1:0] = ev_enable;
    else
      rd_data = '0;
  end

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= bus_req;
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i)
    begin
      if (bus_req && !wb_we_i)
        wb_dat_o <= rd_data;
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

//--- testbench/dsl_cmp_model.sv
`default_nettype none
// Analog comparators facing the supervisor
module dsl_cmp_model (
  // Levels in millivolts and degrees
  input var int sup_i,
  input var int bus_i,
  input var int head_i,
  input var int tmp_i,
  // Comparator pins
  output logic s_lo_o,
  output logic s_hi_o,
  output logic b_uvl_o,
  output logic b_uvu_o,
  output logic b_ovu_o,
  output logic b_ovl_o,
  output logic h_ok_o,
  output logic t_hi_o,
  output logic t_lo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Set and clear pins sit on either side of each band
  assign s_lo_o = sup_i < dsl_pkg::SUPPLY_DIS_MV;
  assign s_hi_o = sup_i > dsl_pkg::SUPPLY_ENA_MV;
  assign b_uvl_o = bus_i < dsl_pkg::BUS_UVL_MV;
  assign b_uvu_o = bus_i > dsl_pkg::BUS_UVU_MV;
  assign b_ovu_o = bus_i > dsl_pkg::BUS_OVU_MV;
  assign b_ovl_o = bus_i < dsl_pkg::BUS_OVL_MV;
  assign h_ok_o = head_i > dsl_pkg::HEAD_RUN_MV;
  assign t_hi_o = tmp_i > dsl_pkg::TEMP_DIS_C;
  assign t_lo_o = tmp_i < dsl_pkg::TEMP_ENA_C;
endmodule
`default_nettype wire

//--- testbench/dsl_top_sva.sv
`default_nettype none
// Watches mode outputs and bus timing
module dsl_top_sva (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Fault set pins and headroom pin
  input wire logic supply_below_dis_i,
  input wire logic bus_below_uvl_i,
  input wire logic bus_above_ovu_i,
  input wire logic temp_above_dis_i,
  input wire logic headroom_above_run_i,
  // Mode outputs
  input wire logic amp_ground_o,
  input wire logic amp_charge_en_o,
  input wire logic amp_loop_en_o,
  input wire logic switching_en_o,
  input wire logic full_ref_o,
  input wire logic inhibit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  // High while any fault set pin is active
  logic any_set;
  assign any_set = supply_below_dis_i | bus_below_uvl_i | bus_above_ovu_i
    | temp_above_dis_i;
  // Hot pin held past the synchroniser
  sequence s_hot_held;
    temp_above_dis_i [*5];
  endsequence
  // One-cycle acknowledge
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_hot_inhibits:
    assert property (s_hot_held |=> inhibit_o)
    else $error("no inhibit after overtemperature");
  a_inhibit_idles:
    assert property (inhibit_o |-> amp_ground_o)
    else $error("not idle while inhibited");
  a_one_mode:
    assert property ($onehot({amp_ground_o, amp_charge_en_o, amp_loop_en_o}))
    else $error("amplifier mode not unique");
  a_mode_outputs:
    assert property (switching_en_o == !amp_ground_o
      && full_ref_o == amp_loop_en_o)
    else $error("switching or reference mismatch");
  a_release_starts:
    assert property ($fell(inhibit_o) |-> amp_charge_en_o)
    else $error("no start after inhibit release");
  a_run_needs_head:
    assert property ($rose(amp_loop_en_o) |-> $past(amp_charge_en_o)
      && $past(headroom_above_run_i, 4))
    else $error("run entered without headroom");
  a_run_stays:
    assert property (amp_loop_en_o ##1 !inhibit_o |-> amp_loop_en_o)
    else $error("run left without inhibit");
  a_sync_delay:
    assert property ($rose(inhibit_o) |-> $past(any_set, 4))
    else $error("inhibit rose too early");
  a_ack_pulse:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
    else $error("acknowledge not one cycle");
  a_idle_data:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside acknowledge");
endmodule
bind dsl_top dsl_top_sva u_sva (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .supply_below_dis_i, .bus_below_uvl_i,
  .bus_above_ovu_i, .temp_above_dis_i, .headroom_above_run_i,
  .amp_ground_o, .amp_charge_en_o, .amp_loop_en_o, .switching_en_o,
  .full_ref_o, .inhibit_o);
`default_nettype wire

//--- testbench/dsl_top_tb.sv
`default_nettype none
// Drives comparator levels and checks status, events and irq
module dsl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset, bus
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, irq_o, inhibit_o, switching_en_o, full_ref_o;
  logic amp_ground_o, amp_charge_en_o, amp_loop_en_o;
  // Comparator pins
  logic supply_below_dis_i, supply_above_ena_i, bus_below_uvl_i;
  logic bus_above_uvu_i, bus_above_ovu_i, bus_below_ovl_i;
  logic headroom_above_run_i, temp_above_dis_i, temp_below_ena_i;
  // Levels, counters, expected flags and state
  int sup = 6000, bus = 800, head = 0, tmp = 25;
  int err_count = 0, compares = 0;
  logic [4:0] ef;
  dsl_pkg::dsl_state_t es;
  // Supply, bus, headroom, temperature per step
  int tbl[21][4] = '{'{6000,800,0,25}, '{7000,800,0,25},
    '{8000,800,0,25}, '{8000,450,0,25}, '{8000,300,0,25},
    '{8000,450,0,25}, '{8000,800,1300,25}, '{8000,800,1000,25},
    '{8000,800,1250,25}, '{8000,1200,1250,25}, '{8000,1300,1250,25},
    '{8000,1200,1300,25}, '{8000,800,1300,25}, '{8000,800,1300,140},
    '{8000,800,1300,150}, '{8000,800,1300,140}, '{8000,800,1300,120},
    '{8000,800,0,150}, '{8000,800,0,120}, '{8000,800,1300,150},
    '{8000,800,1300,120}};
  dsl_top dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .supply_below_dis_i, .supply_above_ena_i, .bus_below_uvl_i,
    .bus_above_uvu_i, .bus_above_ovu_i, .bus_below_ovl_i,
    .headroom_above_run_i, .temp_above_dis_i, .temp_below_ena_i,
    .amp_ground_o, .amp_charge_en_o, .amp_loop_en_o,
    .switching_en_o, .full_ref_o, .inhibit_o, .irq_o);
  dsl_cmp_model cmp (.sup_i(sup), .bus_i(bus), .head_i(head),
    .tmp_i(tmp), .s_lo_o(supply_below_dis_i), .s_hi_o(supply_above_ena_i),
    .b_uvl_o(bus_below_uvl_i), .b_uvu_o(bus_above_uvu_i),
    .b_ovu_o(bus_above_ovu_i), .b_ovl_o(bus_below_ovl_i),
    .h_ok_o(headroom_above_run_i), .t_hi_o(temp_above_dis_i),
    .t_lo_o(temp_below_ena_i));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // Prints counts and verdict, then stops
  task automatic close_out;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compares one value against its expectation
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, waiting a bounded time for acknowledge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      close_out();
    end
  endtask
  // Hysteretic flag update
  function automatic logic upd(logic p, logic s, logic c);
    return s ? 1'b1 : (c ? 1'b0 : p);
  endfunction
  // Mode pins, switching, reference and inhibit expected per state
  function automatic logic [5:0] exp_out(dsl_pkg::dsl_state_t s, logic i);
    return {s == dsl_pkg::ST_IDLE, s == dsl_pkg::ST_START,
      s == dsl_pkg::ST_RUN, s != dsl_pkg::ST_IDLE, s == dsl_pkg::ST_RUN, i};
  endfunction
  // Applies levels, settles, then checks the status word
  task automatic step(input int s, input int b, input int h, input int t);
    logic inh;
    sup <= s;
    bus <= b;
    head <= h;
    tmp <= t;
    repeat (10) @(posedge clk_i);
    ef[0] = upd(ef[0], s < 6750, s > 7500);
    ef[1] = upd(ef[1], b < 400, b > 500);
    ef[2] = upd(ef[2], b > 1250, b < 1150);
    ef[3] = h > 1250;
    ef[4] = upd(ef[4], t > 145, t < 130);
    inh = ef[0] | ef[1] | ef[2] | ef[4];
    if (inh)
      es = dsl_pkg::ST_IDLE;
    else
    begin
      if (es == dsl_pkg::ST_IDLE)
        es = dsl_pkg::ST_START;
      if (es == dsl_pkg::ST_START && ef[3])
        es = dsl_pkg::ST_RUN;
    end
    wb(1'b0, 8'h00, 32'h0);
    check(q, {24'h0, es, inh, ef});
    check({26'h0, amp_ground_o, amp_charge_en_o, amp_loop_en_o,
      switching_en_o, full_ref_o, inhibit_o},
      {26'h0, exp_out(es, inh)});
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h6628));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ef = 5'h00;
    es = dsl_pkg::ST_IDLE;
    foreach (tbl[i])
      step(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
    wb(1'b1, 8'h08, 32'h1F);
    wb(1'b1, 8'h0C, 32'h08);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    step(8000, 800, 1300, 150);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h19);
    check({31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h0C, 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    check(q, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wb(1'b1, 8'h08, 32'h1F);
    wb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    repeat (30)
      step($urandom_range(8500, 6000), $urandom_range(1400, 200),
        $urandom_range(1500, 1000), $urandom_range(160, 100));
    close_out();
  end
endmodule
`default_nettype wire
